// [core/twdsl_pkg.sv]
// Constants and types shared by the two-wire debug slave link
package twdsl_pkg;

  // Field widths of the link frame
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;

  // Rising-edge counts inside one nine-cycle byte
  localparam logic [3:0] LAST_DATA_CNT = 4'h7;
  localparam logic [3:0] SEP_CNT       = 4'h8;

  // Debug register addresses the link itself cares about
  localparam logic [6:0] WR_ADDR_LAST  = 7'h30;
  localparam logic [6:0] RD_ADDR_LAST  = 7'h20;
  localparam logic [6:0] BUS_CTL_ADDR  = 7'h17;
  localparam logic [6:0] BUS_STAT_ADDR = 7'h17;

  // Bit positions inside the bus control and bus status bytes
  localparam int PERMIT_BIT = 0;
  localparam int GRANT_BIT  = 0;

  // Values after reset
  localparam logic       RST_PERMIT = 1'b0;
  localparam logic       RST_GRANT  = 1'b0;
  localparam logic       RST_SEP    = 1'b1;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [6:0] RST_ADDR   = 7'h00;
  localparam logic [3:0] RST_CNT    = 4'h0;

  // Frame sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ
  } twdsl_state_type;

  // Write strobe towards the debug register map
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic [7:0] data;
  } twdsl_wr_type;

  // Read strobe towards the debug register map
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } twdsl_rd_type;

endpackage

// [core/twdsl_sync2.sv]
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/10ps
`default_nettype none
module twdsl_sync2
  import twdsl_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Levels from another domain and their synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  initial begin
    if (WIDTH < 1) begin
      $error("twdsl_sync2: WIDTH must be at least 1");
    end
  end

  // First stage is read by the second stage only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;

endmodule
`default_nettype wire

// [core/twdsl_link_rx.sv]
// Link-clock domain capture of the incoming data bit
`timescale 1ns/10ps
`default_nettype none
module twdsl_link_rx
  import twdsl_pkg::*;
(
  // Link clock and data pin
  input  wire logic debug_clock_line,
  input  wire logic debug_data_line_i,
  // Bit taken at the last rising edge, stable until the next one
  output logic      rx_bit_ff
);

  // No reset: the link clock may stand still, the bit is plain data
  always_ff @(posedge debug_clock_line) begin
    rx_bit_ff <= debug_data_line_i;
  end

endmodule
`default_nettype wire

// [core/twdsl_slave.sv]
// Two-wire debug link slave: framing, register strobes and bus grant
`timescale 1ns/10ps
`default_nettype none
module twdsl_slave
  import twdsl_pkg::*;
(
  // System clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Link pins
  input  wire logic         debug_clock_line,
  input  wire logic         debug_data_line_i,
  output logic              debug_data_line_o,
  output logic              debug_data_line_oe,
  // Debug register map strobes
  output twdsl_wr_type      reg_wr,
  output twdsl_rd_type      reg_rd,
  input  wire logic [7:0]   reg_rd_data,
  // External bus grant
  input  wire logic         external_bus_request,
  output logic              bus_grant_output,
  // Break towards the processor
  input  wire logic         break_request,
  output logic              cpu_halt
);

  // Synchronised link and request levels
  logic            clk_s;
  logic            dat_s;
  logic            rx_s;
  logic            req_s;
  logic [3:0]      sync_bus;
  logic            rx_bit_link;
  logic            clk_prev_ff;
  logic            dat_prev_ff;
  logic            rise_ff;
  logic            rise_d;
  logic            fall_det;
  logic            start_det;

  // Sequencer state
  twdsl_state_type state_ff;
  logic [3:0]      cnt_ff;
  logic [7:0]      rx_sh_ff;
  logic [7:0]      tx_sh_ff;
  logic [6:0]      addr_ff;
  logic            sep_ff;
  logic            tx_bit_ff;
  logic            tx_oe_ff;
  twdsl_wr_type    wr_ff;
  twdsl_rd_type    rd_ff;
  logic            permit_ff;
  logic            grant_ff;
  logic            halt_ff;
  logic            busy;
  logic [7:0]      load_val;
  logic [7:0]      rx_next;
  logic [6:0]      nxt_wr_addr;
  logic [6:0]      nxt_rd_addr;

  // Capture of the data bit on the link clock itself
  twdsl_link_rx u_link_rx (
    .debug_clock_line  (debug_clock_line),
    .debug_data_line_i (debug_data_line_i),
    .rx_bit_ff         (rx_bit_link)
  );

  // Link lines, captured bit and bus request into the core domain
  twdsl_sync2 #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({debug_clock_line, debug_data_line_i, rx_bit_link, external_bus_request}),
    .sync_out (sync_bus)
  );

  // Split the synchronised bus back into its levels
  assign clk_s = sync_bus[3];
  assign dat_s = sync_bus[2];
  assign rx_s  = sync_bus[1];
  assign req_s = sync_bus[0];

  // Previous synchronised samples for edge detection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_prev_ff <= 1'b0;
      dat_prev_ff <= 1'b0;
      rise_ff     <= 1'b0;
    end else begin
      clk_prev_ff <= clk_s;
      dat_prev_ff <= dat_s;
      rise_ff     <= clk_s & ~clk_prev_ff;
    end
  end

  // Rising edge acted on one cycle late so the captured bit has settled
  assign rise_d    = rise_ff;
  assign fall_det  = ~clk_s & clk_prev_ff;
  // Only a falling data line with the clock high starts a command
  assign start_det = clk_s & clk_prev_ff & dat_prev_ff & ~dat_s;
  assign rx_next   = {rx_sh_ff[6:0], rx_s};

  // Next addresses, saturating at the top of each space
  assign nxt_wr_addr = (addr_ff >= WR_ADDR_LAST) ? addr_ff : addr_ff + 7'h01;
  assign nxt_rd_addr = (addr_ff >= RD_ADDR_LAST) ? addr_ff : addr_ff + 7'h01;

  // Shifting unless parked on a separator of one between bytes
  assign busy = (state_ff != ST_IDLE) && !((cnt_ff == RST_CNT) && sep_ff);

  // Read data source: the bus status byte is answered locally
  always_comb begin
    load_val = reg_rd_data;
    if (rd_ff.addr == BUS_STAT_ADDR) begin
      load_val            = RST_BYTE;
      load_val[GRANT_BIT] = grant_ff;
    end
  end

  // Frame sequencer: address byte, then repeated data bytes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= RST_CNT;
      sep_ff   <= RST_SEP;
    end else if (start_det) begin
      state_ff <= ST_ADDR;
      cnt_ff   <= RST_CNT;
      sep_ff   <= 1'b0;
    end else if (rise_d && state_ff != ST_IDLE) begin
      if (cnt_ff == SEP_CNT) begin
        cnt_ff <= RST_CNT;
        sep_ff <= rx_s;
        if (state_ff == ST_ADDR) begin
          state_ff <= rx_sh_ff[0] ? ST_READ : ST_WRITE;
        end
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
        sep_ff <= 1'b0;
      end
    end
  end

  // Incoming shifter, filled most significant bit first
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_sh_ff <= RST_BYTE;
    end else if (rise_d && state_ff != ST_IDLE && cnt_ff != SEP_CNT) begin
      rx_sh_ff <= rx_next;
    end
  end

  // Register address: loaded from the address byte, then auto-incremented
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_ff <= RST_ADDR;
    end else if (rise_d && state_ff == ST_ADDR && cnt_ff == SEP_CNT) begin
      addr_ff <= rx_sh_ff[7:1];
    end else if (rise_d && state_ff == ST_WRITE && cnt_ff == LAST_DATA_CNT) begin
      addr_ff <= nxt_wr_addr;
    end else if (rise_d && state_ff == ST_READ && cnt_ff == SEP_CNT) begin
      addr_ff <= nxt_rd_addr;
    end
  end

  // Write strobe after the eighth data bit of every byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ff <= '0;
    end else begin
      wr_ff.valid <= rise_d && state_ff == ST_WRITE && cnt_ff == LAST_DATA_CNT;
      wr_ff.addr  <= addr_ff;
      wr_ff.data  <= rx_next;
    end
  end

  // Read strobe at each separator of a read command, one access per byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_ff <= '0;
    end else if (rise_d && cnt_ff == SEP_CNT && state_ff == ST_ADDR && rx_sh_ff[0]) begin
      rd_ff.valid <= 1'b1;
      rd_ff.addr  <= rx_sh_ff[7:1];
    end else if (rise_d && cnt_ff == SEP_CNT && state_ff == ST_READ) begin
      rd_ff.valid <= 1'b1;
      rd_ff.addr  <= nxt_rd_addr;
    end else begin
      rd_ff.valid <= 1'b0;
    end
  end

  // Outgoing shifter: loaded the cycle after the read strobe, drained on falls
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_sh_ff <= RST_BYTE;
    end else if (rd_ff.valid) begin
      tx_sh_ff <= load_val;
    end else if (fall_det && state_ff == ST_READ && cnt_ff != SEP_CNT) begin
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  // Data pin driver: only during the eight data cycles of a read byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_bit_ff <= 1'b0;
      tx_oe_ff  <= 1'b0;
    end else if (start_det || state_ff != ST_READ) begin
      tx_bit_ff <= 1'b0;
      tx_oe_ff  <= 1'b0;
    end else if (fall_det) begin
      tx_bit_ff <= tx_sh_ff[7];
      tx_oe_ff  <= (cnt_ff != SEP_CNT);
    end
  end

  // Grant permit, written through the bus control register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      permit_ff <= RST_PERMIT;
    end else if (wr_ff.valid && wr_ff.addr == BUS_CTL_ADDR) begin
      permit_ff <= wr_ff.data[PERMIT_BIT];
    end
  end

  // Bus grant: at once when idle, otherwise after a separator of one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      grant_ff <= RST_GRANT;
    end else if (!permit_ff || !req_s) begin
      grant_ff <= 1'b0;
    end else if (!busy) begin
      grant_ff <= 1'b1;
    end
  end

  // Break reaches the processor halt only; clocks and peripherals run on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      halt_ff <= 1'b0;
    end else begin
      halt_ff <= break_request;
    end
  end

  // Outputs straight from flops
  assign debug_data_line_o  = tx_bit_ff;
  assign debug_data_line_oe = tx_oe_ff;
  assign reg_wr             = wr_ff;
  assign reg_rd             = rd_ff;
  assign bus_grant_output   = grant_ff;
  assign cpu_halt           = halt_ff;

  // Checks on the core domain
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_start_enters_addr: assert property (start_det |=> state_ff == ST_ADDR)
    else $error("start did not enter address phase");

  a_idle_ignores_rise: assert property (state_ff == ST_IDLE && !start_det |=> state_ff == ST_IDLE)
    else $error("sequencer left idle without start");

  a_write_after_eight: assert property (wr_ff.valid |-> $past(state_ff) == ST_WRITE && $past(cnt_ff) == 4'h7)
    else $error("write strobe not after eighth data bit");

  a_write_addr_step: assert property (wr_ff.valid |-> addr_ff == ((wr_ff.addr >= 7'h30) ? wr_ff.addr : wr_ff.addr + 7'h01))
    else $error("write address did not step or saturate");

  a_read_addr_step: assert property (rd_ff.valid && $past(state_ff) == ST_READ && $past(addr_ff) < 7'h20 |->
    rd_ff.addr == $past(addr_ff) + 7'h01)
    else $error("read address did not step");

  a_read_addr_stop: assert property (rd_ff.valid && $past(state_ff) == ST_READ && $past(addr_ff) >= 7'h20 |->
    rd_ff.addr == $past(addr_ff))
    else $error("read address moved past the top");

  a_rx_shift_msb: assert property (rise_d && state_ff != ST_IDLE && cnt_ff != SEP_CNT |=>
    rx_sh_ff == {$past(rx_sh_ff[6:0]), $past(rx_s)})
    else $error("incoming bit not shifted in at the bottom");

  a_sep_wraps: assert property (rise_d && state_ff != ST_IDLE && cnt_ff == SEP_CNT && !start_det |=>
    cnt_ff == RST_CNT)
    else $error("bit count did not wrap after the separator");

  a_start_clears: assert property (start_det |=> cnt_ff == RST_CNT && !sep_ff)
    else $error("start did not clear count and separator");

  a_read_bit_out: assert property (fall_det && state_ff == ST_READ && cnt_ff != SEP_CNT && !start_det |=>
    tx_oe_ff && tx_bit_ff == $past(tx_sh_ff[7]))
    else $error("read bit not driven on the falling edge");

  a_permit_write: assert property (wr_ff.valid && wr_ff.addr == BUS_CTL_ADDR |=>
    permit_ff == $past(wr_ff.data[PERMIT_BIT]))
    else $error("grant permit not taken from the control write");

  a_read_load: assert property (rd_ff.valid |=> tx_sh_ff == $past(load_val))
    else $error("shifter not loaded after read strobe");

  a_status_grant: assert property (rd_ff.valid && rd_ff.addr == 7'h17 |=> tx_sh_ff[0] == $past(grant_ff))
    else $error("bus status byte does not show grant");

  a_drive_only_read: assert property (tx_oe_ff |-> state_ff == ST_READ)
    else $error("data pin driven outside a read");

  a_oe_off_separator: assert property (fall_det && state_ff == ST_READ && cnt_ff == 4'h8 && !start_det |=> !tx_oe_ff)
    else $error("data pin driven in separator cycle");

  a_grant_permit: assert property (grant_ff |-> $past(permit_ff) && $past(req_s))
    else $error("grant without permit or request");

  a_grant_withheld: assert property (!grant_ff && busy |=> !grant_ff)
    else $error("grant given while shifting");

  a_grant_idle: assert property (permit_ff && req_s && !busy |=> grant_ff)
    else $error("idle request not granted at once");

  a_halt_follows: assert property (cpu_halt == $past(break_request))
    else $error("halt does not follow break");

  c_write_byte: cover property (wr_ff.valid);
  c_read_byte: cover property (rd_ff.valid ##[1:100] tx_oe_ff);
  c_block_write_top: cover property (wr_ff.valid && wr_ff.addr == 7'h30);
  c_grant: cover property (!grant_ff ##1 grant_ff);

endmodule
`default_nettype wire

// [core/twdsl_dummy_guard.sv]
// Spare core file: holds no logic of its own

// [testbench/twdsl_emu.sv]
// Link master model: makes the link clock and drives the data wire
`timescale 1ns/10ps
`default_nettype none
module twdsl_emu #(
  parameter int HALF_NS = 600, // Half link period, well below half the system clock rate
  parameter int SKEW_NS = 37   // Phase offset of each command against the system clock
) (
  // Link pins
  output logic      debug_clock_line,
  output logic      data_o,
  output logic      data_oe,
  // Resolved level of the data wire
  input  wire logic data_in
);
  // Idle: clock stands high, data driven high
  initial begin
    debug_clock_line = 1'b1;
    data_o = 1'b1;
    data_oe = 1'b1;
  end
  // One bit out: data moves only while clock low, clock left high
  task automatic bit_out(input logic b);
    debug_clock_line = 1'b0;
    #(HALF_NS/2);
    data_oe = 1'b1;
    data_o = b;
    #(HALF_NS/2);
    debug_clock_line = 1'b1;
    #(HALF_NS);
  endtask
  // One bit in: wire released, sampled at the rising edge
  task automatic bit_in(output logic b);
    debug_clock_line = 1'b0;
    data_oe = 1'b0;
    #(HALF_NS);
    debug_clock_line = 1'b1;
    b = data_in;
    #(HALF_NS);
  endtask
  // Start, address MSB first, direction bit and separator
  task automatic cmd(input logic [6:0] a, input logic rw, input logic sep);
    #(SKEW_NS);
    data_o = 1'b0;
    #(HALF_NS);
    for (int i = 6; i >= 0; i--) bit_out(a[i]);
    bit_out(rw);
    bit_out(sep);
  endtask
  // Nine-cycle write byte; separator 1 before a new start, 0 to hold the bus
  task automatic wr_byte(input logic [7:0] d, input logic sep);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_out(sep);
  endtask
  // Nine-cycle read byte, separator sent by the master
  task automatic rd_byte(output logic [7:0] d, input logic sep);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(sep);
  endtask
endmodule
`default_nettype wire

// [testbench/twdsl_slave_tb.sv]
// Self-checking bench for the two-wire debug link slave
`timescale 1ns/10ps
`default_nettype none
module twdsl_slave_tb;
  import twdsl_pkg::*;
  // Clock, reset and pins
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         link_clk, emu_o, emu_oe, dev_o, dev_oe, data_line;
  logic         external_bus_request = 1'b0;
  logic         break_request = 1'b0;
  logic         bus_grant_output, cpu_halt;
  twdsl_wr_type reg_wr;
  twdsl_rd_type reg_rd;
  logic [7:0]   reg_rd_data, got;
  logic [14:0]  wq[$];
  int           errors = 0;
  int           n_checks = 0;
  // Rows {rw, addr, data}: writes to 10, 13 and 00, then reads of 00, 10 and 03
  localparam logic [15:0] ROWS [6] = '{16'h10a5, 16'h133c, 16'h0081, 16'h8000, 16'h9000, 16'h8300};
  always #50 core_clk = ~core_clk;
  // Data wire with pull-up
  assign data_line = dev_oe ? dev_o : (emu_oe ? emu_o : 1'b1);
  // Register map model answers from the address
  assign reg_rd_data = {1'b1, reg_rd.addr} ^ 8'h5a;
  twdsl_slave i_twdsl_slave (.core_clk(core_clk), .rst_n(rst_n), .debug_clock_line(link_clk),
    .debug_data_line_i(data_line), .debug_data_line_o(dev_o), .debug_data_line_oe(dev_oe),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .external_bus_request(external_bus_request),
    .bus_grant_output(bus_grant_output), .break_request(break_request), .cpu_halt(cpu_halt));
  twdsl_emu i_twdsl_emu (.debug_clock_line(link_clk), .data_o(emu_o), .data_oe(emu_oe), .data_in(data_line));
  // Log of write strobes
  always @(posedge core_clk) begin
    if (reg_wr.valid === 1'b1) wq.push_back({reg_wr.addr, reg_wr.data});
  end
  function automatic logic [7:0] rdv(input logic [6:0] a);
    return {1'b1, a} ^ 8'h5a;
  endfunction
  task automatic check(input string what, input logic [14:0] exp, input logic [14:0] seen);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wcheck(input logic [6:0] a, input logic [7:0] d);
    logic [14:0] s;
    s = (wq.size() > 0) ? wq.pop_front() : 15'h7fff;
    check("write strobe", {a, d}, s);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 330 us
  initial begin
    #2000000;
    errors++;
    $display("MISMATCH watchdog expected end seen timeout");
    end_of_test();
  end
  initial begin
    idle(20);
    check("reset outputs", 15'h0, {10'h0, dev_oe, reg_wr.valid, reg_rd.valid, bus_grant_output, cpu_halt});
    rst_n = 1'b1;
    idle(3);
    // Clocked bits without a start are ignored
    for (int i = 0; i < 9; i++) i_twdsl_emu.bit_out(~i[0]);
    idle(6);
    check("strobes before start", 15'h0, 15'(wq.size()));
    // Ordinary single writes and reads
    foreach (ROWS[i]) begin
      i_twdsl_emu.cmd(ROWS[i][14:8], ROWS[i][15], 1'b1);
      if (ROWS[i][15]) begin
        i_twdsl_emu.rd_byte(got, 1'b1);
        check("read byte", {7'h0, rdv(ROWS[i][14:8])}, {7'h0, got});
      end else begin
        i_twdsl_emu.wr_byte(ROWS[i][7:0], 1'b1);
        idle(6);
        wcheck(ROWS[i][14:8], ROWS[i][7:0]);
      end
    end
    // Block write across the top of the write space
    i_twdsl_emu.cmd(7'h2e, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) i_twdsl_emu.wr_byte(8'h11 * (i + 1), 1'b1);
    idle(6);
    for (int i = 0; i < 4; i++) wcheck((i < 2) ? 7'(7'h2e + i) : WR_ADDR_LAST, 8'h11 * (i + 1));
    // Block read across the top of the read space
    i_twdsl_emu.cmd(7'h1f, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      i_twdsl_emu.rd_byte(got, 1'b1);
      check("block read", {7'h0, rdv((i == 0) ? 7'h1f : RD_ADDR_LAST)}, {7'h0, got});
    end
    // Bus request refused until the permit is written
    external_bus_request = 1'b1;
    idle(8);
    check("grant without permit", 15'h0, 15'(bus_grant_output));
    i_twdsl_emu.cmd(BUS_CTL_ADDR, 1'b0, 1'b1);
    i_twdsl_emu.wr_byte(8'h01, 1'b1);
    idle(4);
    check("grant when idle", 15'h1, 15'(bus_grant_output));
    i_twdsl_emu.cmd(BUS_STAT_ADDR, 1'b1, 1'b1);
    i_twdsl_emu.rd_byte(got, 1'b1);
    check("grant status", 15'h1, {7'h0, got});
    external_bus_request = 1'b0;
    idle(4);
    check("grant dropped", 15'h0, 15'(bus_grant_output));
    // Separator 0 holds the grant back, separator 1 releases it
    i_twdsl_emu.cmd(7'h10, 1'b0, 1'b0);
    i_twdsl_emu.wr_byte(8'h77, 1'b0);
    external_bus_request = 1'b1;
    idle(8);
    check("grant while busy", 15'h0, 15'(bus_grant_output));
    i_twdsl_emu.wr_byte(8'h78, 1'b1);
    idle(4);
    check("grant after separator", 15'h1, 15'(bus_grant_output));
    wcheck(BUS_CTL_ADDR, 8'h01);
    wcheck(7'h10, 8'h77);
    wcheck(7'h11, 8'h78);
    external_bus_request = 1'b0;
    // Break halts the processor one cycle later
    break_request = 1'b1;
    idle(2);
    check("halt", 15'h1, 15'(cpu_halt));
    break_request = 1'b0;
    idle(2);
    check("halt released", 15'h0, 15'(cpu_halt));
    // Reset in mid-run clears the permit, so a standing request stays unanswered
    external_bus_request = 1'b1;
    rst_n = 1'b0;
    idle(3);
    check("grant in reset", 15'h0, 15'(bus_grant_output));
    rst_n = 1'b1;
    idle(8);
    check("grant after reset", 15'h0, 15'(bus_grant_output));
    end_of_test();
  end
endmodule
`default_nettype wire
